// [core/cbt_cfg.svh]
// named constants for the can bit timing block
`ifndef CBT_CFG_SVH
`define CBT_CFG_SVH

// segment length limits in time quanta
`define CBT_SYNC_TQ      4'h1
`define CBT_PROP_MIN     4'h1
`define CBT_PROP_MAX     4'h8
`define CBT_PH1_MIN      4'h2
`define CBT_PH1_MAX      4'h8
`define CBT_PH2_MIN      4'h2
`define CBT_PH2_MAX      4'h8
`define CBT_SJW_MIN      3'h1
`define CBT_SJW_MAX      3'h4
`define CBT_BIT_MIN      5'h08
`define CBT_BIT_MAX      5'h19

// clock divider select: 0..4 gives 1, 2, 4, 8, 16
`define CBT_DIV_SEL_MAX  3'h4
`define CBT_DIV_BASE     5'h01

// counter helpers
`define CBT_CNT_ZERO     4'h0
`define CBT_CNT_ONE      4'h1
`define CBT_ERR_ONE      5'h01

// bus levels
`define CBT_RECESSIVE    1'h1

// interframe space phase codes from the frame logic
`define CBT_IFS_INTERMISSION 2'h0
`define CBT_IFS_SUSPEND      2'h1
`define CBT_IFS_IDLE         2'h2

`endif

// [core/cbt_pkg.sv]
// types shared by the can bit timing block
package cbt_pkg;
	typedef enum logic [1:0] {SEG_SYNC, SEG_PROP, SEG_PH1, SEG_PH2} cbt_seg_t;
	typedef enum logic {MODE_INIT, MODE_RUN} cbt_mode_t;
endpackage : cbt_pkg

// [core/cbt_tq_gen.sv]
// time quantum tick generator: clock divider followed by baud rate prescaler
`timescale 1ns/100ps
`default_nettype none
`include "cbt_cfg.svh"
module cbt_tq_gen
	import cbt_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// control
	input  wire logic       enable,
	input  wire logic       restart,
	input  wire logic [2:0] div_sel,
	input  wire logic [3:0] brp,
	// tick at the end of each quantum
	output logic            tq_tick
);
	logic [3:0] div_cnt_q;
	logic [3:0] pre_cnt_q;
	logic [3:0] div_top;
	logic       div_hit;
	logic       pre_hit;

	assign div_top = 4'((`CBT_DIV_BASE << div_sel) - `CBT_DIV_BASE);
	assign div_hit = (div_cnt_q == div_top);
	assign pre_hit = (pre_cnt_q == brp);
	// restart wins so a resync edge opens a full fresh quantum
	assign tq_tick = enable && !restart && div_hit && pre_hit;

	always_ff @(posedge ref_clk) begin
		if (rst || !enable || restart || div_hit) begin
			div_cnt_q <= `CBT_CNT_ZERO;
		end else begin
			div_cnt_q <= div_cnt_q + `CBT_CNT_ONE;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || !enable || restart || (div_hit && pre_hit)) begin
			pre_cnt_q <= `CBT_CNT_ZERO;
		end else if (div_hit) begin
			pre_cnt_q <= pre_cnt_q + `CBT_CNT_ONE;
		end
	end

	tq_spacing_a: assert property (@(posedge ref_clk) disable iff (rst)
		(tq_tick && (div_sel != 3'h0 || brp != 4'h0)) |=> !tq_tick)
		else $error("quantum tick repeated faster than the divisor");

endmodule : cbt_tq_gen
`default_nettype wire

// [core/cbt_bit_timing.sv]
// can bit timing engine: config check, segment sequencing, sync, sampling
// How it works
// - a bit runs sync, propagation, first and second phase buffer, in quanta
// - in interframe space a falling bus edge restarts the bit at sync
// - the sample point follows from propagation and phase buffer lengths
// - one quantum is the module clock divided by the divider and then the prescaler
// - sync is fixed at one quantum; propagation accepts 1 to 8
// - first phase buffer accepts 2 to 8 quanta
// - second phase buffer accepts 2 to 8 quanta
// - jump width accepts 1 to 4 quanta
// - total bit length must lie between 8 and 25 quanta
// - any phase correction is capped at the jump width
// - only the phase buffers stretch or shrink to absorb phase error
// - separate requests for transmit done, receive done, bus error, wakeup
// - interframe has intermission, suspend, idle; transmit may start in idle
// - late edge lengthens first buffer, early edge shortens second, capped
// - prescaler divides by field plus one; divider picks 1,2,4,8,16
`timescale 1ns/100ps
`default_nettype none
`include "cbt_cfg.svh"
module cbt_bit_timing
	import cbt_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// timing configuration
	input  wire logic [3:0] cfg_prop,
	input  wire logic [3:0] cfg_phase1,
	input  wire logic [3:0] cfg_phase2,
	input  wire logic [2:0] cfg_sjw,
	input  wire logic [3:0] cfg_brp,
	input  wire logic [2:0] cfg_div_sel,
	input  wire logic       cfg_single_sample,
	input  wire logic       run_req,
	// bus and frame state
	input  wire logic       rx,
	input  wire logic       frame_active,
	input  wire logic [1:0] ifs_phase,
	// events from the frame logic
	input  wire logic       evt_tx_done,
	input  wire logic       evt_rx_done,
	input  wire logic       evt_bus_err,
	input  wire logic       evt_wakeup,
	// status
	output logic            running,
	output logic            cfg_error,
	output logic            tx_permit,
	// bit timing
	output cbt_seg_t        bit_segment,
	output logic            bit_start,
	output logic            sample_pulse,
	output logic            rx_bit,
	// interrupt requests
	output logic            irq_tx_done,
	output logic            irq_rx_done,
	output logic            irq_bus_err,
	output logic            irq_wakeup
);
	cbt_mode_t  mode_q;
	cbt_seg_t   seg_q;
	logic [3:0] cnt_q;
	logic [2:0] ext_q;
	logic [2:0] cut_q;
	logic       done_q;
	logic       rx_last_q;
	logic       rx_bit_q;
	logic       sample_q;
	logic       start_q;
	logic [3:0] irq_q;
	logic       cfg_valid;
	logic [4:0] bit_len;
	logic [3:0] sjw4;
	logic       tq_tick;
	logic       fall_edge;
	logic       hard_sync;
	logic       edge_ok;
	logic       late_edge;
	logic       early_jump;
	logic       early_cut;
	logic       restart;
	logic [4:0] err_late;
	logic [3:0] err_early;
	logic [2:0] ext_new;
	logic [3:0] seg_len;
	logic       last_tq;

	assign sjw4    = {1'b0, cfg_sjw};
	assign bit_len = 5'({1'b0, `CBT_SYNC_TQ}) + 5'(cfg_prop) + 5'(cfg_phase1) + 5'(cfg_phase2);

	// checked in hardware because a bad setting would corrupt every bit on the bus
	always_comb begin
		cfg_valid = 1'b1;
		if (cfg_prop < `CBT_PROP_MIN || cfg_prop > `CBT_PROP_MAX) cfg_valid = 1'b0;
		if (cfg_phase1 < `CBT_PH1_MIN || cfg_phase1 > `CBT_PH1_MAX) cfg_valid = 1'b0;
		if (cfg_phase2 < `CBT_PH2_MIN || cfg_phase2 > `CBT_PH2_MAX) cfg_valid = 1'b0;
		if (cfg_sjw < `CBT_SJW_MIN || cfg_sjw > `CBT_SJW_MAX) cfg_valid = 1'b0;
		if (bit_len < `CBT_BIT_MIN || bit_len > `CBT_BIT_MAX) cfg_valid = 1'b0;
		if (cfg_phase1 < cfg_phase2 || cfg_phase1 < sjw4) cfg_valid = 1'b0;
		if (cfg_phase2 < sjw4) cfg_valid = 1'b0;
		if (cfg_div_sel > `CBT_DIV_SEL_MAX) cfg_valid = 1'b0;
		if (!cfg_single_sample) cfg_valid = 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mode_q <= MODE_INIT;
		end else begin
			case (mode_q)
				MODE_INIT: if (run_req && cfg_valid) mode_q <= MODE_RUN;
				MODE_RUN:  if (!run_req || !cfg_valid) mode_q <= MODE_INIT;
				default:   mode_q <= MODE_INIT;
			endcase
		end
	end

	assign running   = (mode_q == MODE_RUN);
	assign cfg_error = !cfg_valid;
	assign tx_permit = running && !frame_active && (ifs_phase == `CBT_IFS_IDLE);

	cbt_tq_gen u_tq_gen (
		.ref_clk (ref_clk),
		.rst     (rst),
		.enable  (running),
		.restart (restart),
		.div_sel (cfg_div_sel),
		.brp     (cfg_brp),
		.tq_tick (tq_tick)
	);

	// edges are seen at clock rate so a hard sync aligns to within one clock
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_last_q <= `CBT_RECESSIVE;
		end else begin
			rx_last_q <= rx;
		end
	end

	assign fall_edge = running && (rx_last_q == `CBT_RECESSIVE) && (rx != `CBT_RECESSIVE);
	assign hard_sync = fall_edge && !frame_active;
	// one resync per bit, and only after a recessive sample
	assign edge_ok   = fall_edge && frame_active && !done_q && (rx_bit_q == `CBT_RECESSIVE);

	assign err_late  = (seg_q == SEG_PROP) ? 5'(cnt_q) + `CBT_ERR_ONE
	                                        : 5'(cfg_prop) + 5'(cnt_q) + `CBT_ERR_ONE;
	assign ext_new   = (err_late > 5'(cfg_sjw)) ? cfg_sjw : err_late[2:0];
	assign late_edge = edge_ok && (seg_q == SEG_PROP || seg_q == SEG_PH1);
	assign err_early = 4'(cfg_phase2 - 4'(cut_q) - cnt_q);
	assign early_jump = edge_ok && (seg_q == SEG_PH2) && (err_early <= sjw4);
	assign early_cut  = edge_ok && (seg_q == SEG_PH2) && (err_early > sjw4);
	assign restart    = hard_sync || early_jump;

	always_comb begin
		case (seg_q)
			SEG_SYNC: seg_len = `CBT_SYNC_TQ;
			SEG_PROP: seg_len = cfg_prop;
			SEG_PH1:  seg_len = cfg_phase1 + 4'(late_edge ? ext_new : ext_q);
			// the cut counts in the edge's own quantum so the count never runs past the end
			SEG_PH2:  seg_len = cfg_phase2 - 4'(early_cut ? cfg_sjw : cut_q);
			default:  seg_len = `CBT_SYNC_TQ;
		endcase
	end

	assign last_tq = (cnt_q == 4'(seg_len - `CBT_CNT_ONE));

	always_ff @(posedge ref_clk) begin
		if (rst || !running) begin
			seg_q  <= SEG_SYNC;
			cnt_q  <= `CBT_CNT_ZERO;
			ext_q  <= 3'h0;
			cut_q  <= 3'h0;
			done_q <= 1'b0;
		end else if (restart) begin
			seg_q  <= SEG_SYNC;
			cnt_q  <= `CBT_CNT_ZERO;
			ext_q  <= 3'h0;
			cut_q  <= 3'h0;
			done_q <= 1'b1;
		end else begin
			if (late_edge) begin
				ext_q  <= ext_new;
				done_q <= 1'b1;
			end
			if (early_cut) begin
				cut_q  <= cfg_sjw;
				done_q <= 1'b1;
			end
			if (tq_tick) begin
				if (last_tq) begin
					cnt_q <= `CBT_CNT_ZERO;
					case (seg_q)
						SEG_SYNC: seg_q <= SEG_PROP;
						SEG_PROP: seg_q <= SEG_PH1;
						SEG_PH1:  seg_q <= SEG_PH2;
						SEG_PH2: begin
							seg_q  <= SEG_SYNC;
							ext_q  <= 3'h0;
							cut_q  <= 3'h0;
							done_q <= 1'b0;
						end
						default:  seg_q <= SEG_SYNC;
					endcase
				end else begin
					cnt_q <= cnt_q + `CBT_CNT_ONE;
				end
			end
		end
	end

	// single sample at the end of the first phase buffer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			rx_bit_q <= `CBT_RECESSIVE;
			sample_q <= 1'b0;
		end else begin
			sample_q <= 1'b0;
			if (running && !restart && tq_tick && seg_q == SEG_PH1 && last_tq) begin
				rx_bit_q <= rx;
				sample_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			start_q <= 1'b0;
		end else begin
			start_q <= restart || (running && tq_tick && seg_q == SEG_PH2 && last_tq);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			irq_q <= 4'h0;
		end else begin
			irq_q <= {evt_wakeup, evt_bus_err, evt_rx_done, evt_tx_done};
		end
	end

	assign bit_segment  = seg_q;
	assign bit_start    = start_q;
	assign sample_pulse = sample_q;
	assign rx_bit       = rx_bit_q;
	assign irq_tx_done  = irq_q[0];
	assign irq_rx_done  = irq_q[1];
	assign irq_bus_err  = irq_q[2];
	assign irq_wakeup   = irq_q[3];

	sync_one_tq_a: assert property (@(posedge ref_clk) disable iff (rst)
		(running && !restart && tq_tick && seg_q == SEG_SYNC) |=> (seg_q == SEG_PROP || !running))
		else $error("sync segment lasted other than one quantum");

	invalid_init_a: assert property (@(posedge ref_clk) disable iff (rst)
		!cfg_valid |=> (mode_q == MODE_INIT))
		else $error("left initialization with invalid timing");

	// running now means the setting was checked at the previous edge
	bit_length_a: assert property (@(posedge ref_clk) disable iff (rst)
		running |-> ($past(bit_len) >= `CBT_BIT_MIN && $past(bit_len) <= `CBT_BIT_MAX))
		else $error("running with bit length out of range");

	hard_sync_a: assert property (@(posedge ref_clk) disable iff (rst)
		(hard_sync && running) |=> (seg_q == SEG_SYNC && cnt_q == 4'h0 && bit_start))
		else $error("hard sync did not restart the bit");

	sample_point_a: assert property (@(posedge ref_clk) disable iff (rst)
		sample_pulse |-> (seg_q == SEG_PH2 && cnt_q == 4'h0 && $past(seg_q) == SEG_PH1))
		else $error("sample taken away from the phase buffer boundary");

	ext_capped_a: assert property (@(posedge ref_clk) disable iff (rst)
		(ext_q <= cfg_sjw) && (cut_q == 3'h0 || cut_q == cfg_sjw))
		else $error("phase correction exceeds jump width");

	late_stretch_a: assert property (@(posedge ref_clk) disable iff (rst)
		(late_edge && !restart && running) |=> (ext_q == $past(ext_new) || seg_q == SEG_SYNC))
		else $error("late edge did not lengthen the first buffer");

	irq_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		(evt_bus_err && !evt_wakeup) |=> (irq_bus_err && !irq_wakeup))
		else $error("bus error request not raised on its own line");

	tx_idle_a: assert property (@(posedge ref_clk) disable iff (rst)
		tx_permit |-> (running && ifs_phase == `CBT_IFS_IDLE && !frame_active))
		else $error("transmit permitted outside bus idle");

endmodule : cbt_bit_timing
`default_nettype wire

// [verif/cbt_bus_node.sv]
// behavioural far node on the shared bus: pulls the line dominant on command
`timescale 1ns/100ps
`default_nettype none
module cbt_bus_node (
	// clock
	input  wire logic ref_clk,
	// bus level seen by the block
	output var logic  rx
);
	// released bus floats to recessive through the termination
	initial rx = 1'b1;

	// dominant for n clocks, then released; the time of the call sets a prompt or slow node
	task automatic dominant(input int n);
		@(posedge ref_clk);
		rx <= 1'b0;
		repeat (n) @(posedge ref_clk);
		rx <= 1'b1;
	endtask : dominant
endmodule : cbt_bus_node
`default_nettype wire

// [verif/cbt_bit_timing_tb.sv]
// self-checking bench for the can bit timing engine
`timescale 1ns/100ps
`default_nettype none
module cbt_bit_timing_tb
	import cbt_pkg::*;
;
	logic       ref_clk = 0, rst = 1, single = 1, run_req = 0, frame_active = 0;
	logic [3:0] prop = 1, ph1 = 3, ph2 = 3, brp = 0, evt = 0;
	logic [2:0] sjw = 1, dsel = 0;
	logic [1:0] ifs = 0;
	wire logic  rx, running, cfg_error, tx_permit, bit_start, sample_pulse, rx_bit;
	wire logic [3:0] irq;
	cbt_seg_t   seg;
	int         errors = 0, n_compared = 0, cyc = 0, since = 0, last_per = 0;
	int         smp_off = 0, smp_cnt = 0, last_smp = 0, d1;
	// prop ph1 ph2 sjw brp div single valid, one nibble each
	logic [31:0] cfgs [19] = '{32'h1331_0011, 32'h0331_0010, 32'h9331_0010,
		32'h1131_0010, 32'h1931_0010, 32'h1311_0010, 32'h1891_0010, 32'h1330_0010,
		32'h1885_0010, 32'h1884_0011, 32'h8884_0011, 32'h1523_0010, 32'h4334_0010,
		32'h1331_0510, 32'h1331_0411, 32'h1331_F011, 32'h1331_0000, 32'h2232_0010,
		32'h1221_0010};

	cbt_bus_node partner (.ref_clk(ref_clk), .rx(rx));
	cbt_bit_timing uut (.ref_clk(ref_clk), .rst(rst), .cfg_prop(prop), .cfg_phase1(ph1),
		.cfg_phase2(ph2), .cfg_sjw(sjw), .cfg_brp(brp), .cfg_div_sel(dsel),
		.cfg_single_sample(single), .run_req(run_req), .rx(rx),
		.frame_active(frame_active), .ifs_phase(ifs), .evt_tx_done(evt[0]),
		.evt_rx_done(evt[1]), .evt_bus_err(evt[2]), .evt_wakeup(evt[3]),
		.running(running), .cfg_error(cfg_error), .tx_permit(tx_permit),
		.bit_segment(seg), .bit_start(bit_start), .sample_pulse(sample_pulse),
		.rx_bit(rx_bit), .irq_tx_done(irq[0]), .irq_rx_done(irq[1]),
		.irq_bus_err(irq[2]), .irq_wakeup(irq[3]));

	always #2.5 ref_clk = ~ref_clk;

	// bit period, sample offset and samples per bit, measured from the ports
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (bit_start === 1'b1) begin
			last_per <= since + 1;
			since <= 0;
			last_smp <= smp_cnt;
			smp_cnt <= 0;
		end else
			since <= since + 1;
		if (sample_pulse === 1'b1) begin
			smp_off <= since + 1;
			smp_cnt <= smp_cnt + 1;
		end
		if (cyc == 40000) begin
			errors = errors + 1;
			end_sim();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic set_cfg(input logic [31:0] v);
		@(posedge ref_clk);
		{prop, ph1, ph2} <= v[31:20];
		sjw <= v[18:16];
		brp <= v[15:12];
		dsel <= v[10:8];
		single <= v[4];
	endtask : set_cfg

	// bounded wait for the next bit start; period counters settled on return
	task automatic wait_bit;
		int k;
		k = 0;
		@(negedge ref_clk);
		while (bit_start !== 1'b1 && k < 3000) begin
			@(negedge ref_clk);
			k++;
		end
		@(posedge ref_clk);
		#1;
	endtask : wait_bit

	task automatic t_reset;
		@(negedge ref_clk);
		chk({running, bit_start, sample_pulse, rx_bit, tx_permit}, 32'h02);
		chk(seg, SEG_SYNC);
		chk(irq, 0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_ranges;
		foreach (cfgs[i]) begin
			set_cfg(cfgs[i]);
			run_req <= 1'b1;
			repeat (2) @(posedge ref_clk);
			#1;
			chk(cfg_error, !cfgs[i][0]);
			chk(running, cfgs[i][0]);
			@(posedge ref_clk);
			run_req <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
		$display("test ranges done");
	endtask : t_ranges

	task automatic t_timing;
		set_cfg(32'h1331_0011);
		run_req <= 1'b1;
		ifs <= 2'h2;
		repeat (4) @(posedge ref_clk);
		partner.dominant(6);
		wait_bit();
		chk(rx_bit, 0);
		wait_bit();
		chk(last_per, 8);
		chk(last_smp, 1);
		chk(rx_bit, 1);
		d1 = smp_off;
		// same total length, sample point one quantum later
		set_cfg(32'h3222_0011);
		wait_bit();
		wait_bit();
		chk(smp_off, d1 + 1);
		set_cfg(32'h1331_1111);
		repeat (3) wait_bit();
		chk(last_per, 32);
		set_cfg(32'h1331_F411);
		repeat (3) wait_bit();
		chk(last_per, 2048);
		// dropping to an invalid setting while running returns to init
		set_cfg(32'h0331_0010);
		repeat (2) @(posedge ref_clk);
		#1;
		chk(running, 0);
		$display("test timing done");
	endtask : t_timing

	task automatic t_resync;
		set_cfg(32'h1331_0011);
		frame_active <= 1'b1;
		repeat (3) wait_bit();
		partner.dominant(4);
		wait_bit();
		chk(last_per, 9);
		chk(tx_permit, 0);
		// early edge two quanta before the bit end: second buffer cut by the jump width
		wait_bit();
		repeat (4) @(posedge ref_clk);
		partner.dominant(1);
		wait_bit();
		chk(last_per, 7);
		// wider jump width lets the same early edge end the bit at once
		set_cfg(32'h1332_0011);
		wait_bit();
		repeat (4) @(posedge ref_clk);
		partner.dominant(1);
		wait_bit();
		chk(last_per, 7);
		$display("test resync done");
	endtask : t_resync

	task automatic t_events;
		@(posedge ref_clk);
		frame_active <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			ifs <= i[1:0];
			@(negedge ref_clk);
			chk(tx_permit, i == 2);
		end
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			evt <= 4'(1 << i);
			@(posedge ref_clk);
			evt <= 4'h0;
			@(negedge ref_clk);
			chk(irq, 1 << i);
			@(negedge ref_clk);
			chk(irq, 0);
		end
		$display("test events done");
	endtask : t_events

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim

	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_ranges();
		t_timing();
		t_resync();
		t_events();
		end_sim();
	end
endmodule : cbt_bit_timing_tb
`default_nettype wire
